//--- design/ucb_usart_ctrl.sv
// Serial port control, status, shifters and baud generation on Wishbone
//
// Overview of operation
// - Async full-duplex, sync master or slave modes
// - Sync clock source: one master, zero slave
// - Transmit control bit six selects nine-bit send
// - Transmit enable; sync receive overrides it
// - Mode bit selects synchronous or asynchronous
// - Bit three of control registers reads zero
// - High rate divide applies only when asynchronous
// - Shift empty flag, reset to one
// - Ninth transmit data bit held in control
// - Port enable hands pins to serial port
// - Receive control bit six selects nine-bit receive
// - Single receive in sync master, self clearing
// - Continuous receive, overrides single receive
// - Framing error updated with next received byte
// - Overrun clears only by clearing continuous receive
// - Ninth received data bit held in status
// - Baud timer is eight-bit free-running divisor
// - Bit rate divides by 64, 16 or 4 times X+1
// - Divisor write clears baud timer immediately
`timescale 1ns/100ps
module ucb_usart_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [11:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic tx_clock_pin_level,
  output logic tx_clock_pin_drive,
  output logic tx_clock_pin_oe,
  input wire logic rx_data_pin_level,
  output logic rx_data_pin_drive,
  output logic rx_data_pin_oe
);

  function automatic logic idx_hit(input logic [9:0] idx, input logic [9:0] target);
    idx_hit = idx == target;
  endfunction : idx_hit

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [7:0] tx_ctrl_q, rcv_ctrl_q, baud_q, tx_buf_q, rx_buf_q;
  logic framing_error_q, overrun_error_q, rx_ninth_data_q, rx_full_q, tx_full_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  logic tx_line_q, sclk_q;

  wire [9:0] idx = wb_adr[11:2];
  wire req = wb_cyc && wb_stb && !wb_ack;
  wire wr = req && wb_we && wb_sel[0];
  wire wr_tx_ctrl = wr && idx_hit(idx, ucb_pkg::TX_CTRL_IDX);
  wire wr_rcv_ctrl = wr && idx_hit(idx, ucb_pkg::RCV_CTRL_IDX);
  wire wr_baud = wr && idx_hit(idx, ucb_pkg::BAUD_DIV_IDX);
  wire wr_tx_data = wr && idx_hit(idx, ucb_pkg::TX_DATA_IDX);
  wire rd_rx_data = req && !wb_we && idx_hit(idx, ucb_pkg::RX_DATA_IDX);

  // Mode decode
  wire serial_port_enable = rcv_ctrl_q[ucb_pkg::SERIAL_ENABLE_BIT];
  wire continuous_receive_enable = rcv_ctrl_q[ucb_pkg::CONT_RX_BIT];
  wire single_receive_enable = rcv_ctrl_q[ucb_pkg::SINGLE_RX_BIT];
  wire rx9 = rcv_ctrl_q[ucb_pkg::RX_NINTH_SEL_BIT];
  wire sync_mode = tx_ctrl_q[ucb_pkg::SYNC_MODE_BIT];
  wire master = sync_mode && tx_ctrl_q[ucb_pkg::CLOCK_SOURCE_BIT];
  wire high_rate = tx_ctrl_q[ucb_pkg::HIGH_RATE_BIT];
  wire tx9 = tx_ctrl_q[ucb_pkg::TX_NINTH_SEL_BIT];
  wire transmit_enable = tx_ctrl_q[ucb_pkg::TRANSMIT_ENABLE_BIT];
  // Continuous wins; single only counts as master
  wire rx_en_sync = serial_port_enable && sync_mode && (continuous_receive_enable || (single_receive_enable && master));
  wire tx_run = serial_port_enable && transmit_enable && !rx_en_sync;
  wire tx_empty = tx_cnt_q == 4'h0;
  wire rx_on_async = serial_port_enable && !sync_mode && continuous_receive_enable && !overrun_error_q;

  wire [7:0] tx_ctrl_rd = {tx_ctrl_q[7:4], 1'b0, tx_ctrl_q[2], tx_empty, tx_ctrl_q[0]};
  wire [7:0] rcv_ctrl_rd = {rcv_ctrl_q[7:4], 1'b0, framing_error_q, overrun_error_q, rx_ninth_data_q};
  wire [7:0] rd_byte = idx_hit(idx, ucb_pkg::TX_CTRL_IDX) ? tx_ctrl_rd :
                       idx_hit(idx, ucb_pkg::RCV_CTRL_IDX) ? rcv_ctrl_rd :
                       idx_hit(idx, ucb_pkg::BAUD_DIV_IDX) ? baud_q :
                       idx_hit(idx, ucb_pkg::TX_DATA_IDX) ? tx_buf_q :
                       idx_hit(idx, ucb_pkg::RX_DATA_IDX) ? rx_buf_q : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
    end else begin
      wb_ack <= req;
      wb_dat_r <= (req && !wb_we) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator and pin synchronisers
  logic over_tick, bit_tick, mid_tick;
  logic [1:0] pins_s;
  logic sclk_prev_q;

  ucb_baud_gen u_baud (
    .clk(clk),
    .rst(rst),
    .divisor(baud_q),
    .restart(wr_baud),
    .sync_mode(sync_mode),
    .high_rate(high_rate),
    .over_tick(over_tick),
    .bit_tick(bit_tick),
    .mid_tick(mid_tick)
  );

  ucb_sync2 #(.WIDTH(2)) u_pins (
    .clk(clk),
    .rst(rst),
    .async_level({rx_data_pin_level, tx_clock_pin_level}),
    .sync_level(pins_s)
  );

  wire clk_s = pins_s[0];
  wire data_s = pins_s[1];
  // Slave shifts on falling, samples on rising external clock
  wire shift_ev = master ? bit_tick : (sclk_prev_q && !clk_s);
  wire sample_ev = master ? mid_tick : (!sclk_prev_q && clk_s);
  wire tx_ev = sync_mode ? shift_ev : bit_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic rx_done;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_ctrl_q <= ucb_pkg::TX_CTRL_RST & ucb_pkg::TX_CTRL_WMASK;
      rcv_ctrl_q <= ucb_pkg::RCV_CTRL_RST;
      baud_q <= ucb_pkg::BAUD_DIV_RST;
      sclk_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= clk_s;
      if (wr_tx_ctrl) begin
        tx_ctrl_q <= wb_dat_w[7:0] & ucb_pkg::TX_CTRL_WMASK;
      end
      if (wr_baud) begin
        baud_q <= wb_dat_w[7:0];
      end
      if (wr_rcv_ctrl) begin
        rcv_ctrl_q <= wb_dat_w[7:0] & ucb_pkg::RCV_CTRL_WMASK;
      end else if (rx_done && master && !continuous_receive_enable) begin
        rcv_ctrl_q[ucb_pkg::SINGLE_RX_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer and shifter
  wire load_sh = tx_full_q && tx_empty && tx_run;
  wire [8:0] tx_word = {tx_ctrl_q[ucb_pkg::TX_NINTH_DATA_BIT], tx_buf_q};
  wire [10:0] sh_async = tx9 ? {1'b1, tx_word, 1'b0} : {2'b11, tx_buf_q, 1'b0};
  wire [10:0] sh_sync = tx9 ? {2'b11, tx_word} : {3'b111, tx_buf_q};
  wire [3:0] cnt_async = tx9 ? 4'hC : 4'hB;
  wire [3:0] cnt_sync = tx9 ? 4'hA : 4'h9;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_buf_q <= 8'h00;
      tx_full_q <= 1'b0;
      tx_sh_q <= 11'h7FF;
      tx_cnt_q <= 4'h0;
      tx_line_q <= 1'b1;
    end else begin
      if (wr_tx_data) begin
        tx_buf_q <= wb_dat_w[7:0];
      end
      tx_full_q <= wr_tx_data || (tx_full_q && !load_sh);
      if (!serial_port_enable || !transmit_enable) begin
        tx_cnt_q <= 4'h0;
        tx_line_q <= 1'b1;
      end else if (load_sh) begin
        tx_sh_q <= sync_mode ? sh_sync : sh_async;
        tx_cnt_q <= sync_mode ? cnt_sync : cnt_async;
      end else if (tx_ev && !tx_empty && tx_run) begin
        tx_line_q <= tx_sh_q[0];
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        tx_cnt_q <= tx_cnt_q - 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  ucb_pkg::ucb_rx_state_t rx_state_q;
  logic [3:0] os_cnt_q, bit_cnt_q;
  logic [8:0] rx_sh_q;
  logic rx_done_q, rx_framing_error_q;
  logic data_prev_q;

  wire [3:0] os_last = high_rate ? ucb_pkg::POST_HIGH_LAST : ucb_pkg::POST_LOW_LAST;
  wire [3:0] os_half = {1'b0, os_last[3:1]};
  wire [3:0] bit_last = rx9 ? 4'h8 : 4'h7;
  wire os_end = over_tick && (os_cnt_q == os_last);
  assign rx_done = rx_done_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state_q <= ucb_pkg::RX_IDLE;
      os_cnt_q <= 4'h0;
      bit_cnt_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_done_q <= 1'b0;
      rx_framing_error_q <= 1'b0;
      data_prev_q <= 1'b1;
    end else begin
      rx_done_q <= 1'b0;
      data_prev_q <= data_s;
      if (over_tick) begin
        os_cnt_q <= os_end ? 4'h0 : os_cnt_q + 4'h1;
      end
      case (rx_state_q)
        ucb_pkg::RX_IDLE: begin
          bit_cnt_q <= 4'h0;
          // Falling edge only, so a low stop bit is no new start
          if (rx_on_async && data_prev_q && !data_s) begin
            rx_state_q <= ucb_pkg::RX_START;
            os_cnt_q <= 4'h0;
          end else if (rx_en_sync && !overrun_error_q) begin
            rx_state_q <= ucb_pkg::RX_DATA;
          end
        end
        ucb_pkg::RX_START: begin
          if (over_tick && os_cnt_q == os_half) begin
            rx_state_q <= data_s ? ucb_pkg::RX_IDLE : ucb_pkg::RX_DATA;
            os_cnt_q <= 4'h0;
          end
        end
        ucb_pkg::RX_DATA: begin
          if (sync_mode ? sample_ev : os_end) begin
            rx_sh_q <= {data_s, rx_sh_q[8:1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == bit_last) begin
              rx_state_q <= sync_mode ? ucb_pkg::RX_IDLE : ucb_pkg::RX_STOP;
              rx_done_q <= sync_mode;
              rx_framing_error_q <= 1'b0;
            end
          end
        end
        ucb_pkg::RX_STOP: begin
          if (os_end) begin
            rx_state_q <= ucb_pkg::RX_IDLE;
            rx_done_q <= 1'b1;
            rx_framing_error_q <= !data_s;
          end
        end
        default: rx_state_q <= ucb_pkg::RX_IDLE;
      endcase
      if (!serial_port_enable || (!rx_on_async && !rx_en_sync && rx_state_q != ucb_pkg::RX_STOP)) begin
        rx_state_q <= ucb_pkg::RX_IDLE;
      end
    end
  end

  // Receive buffer and error flags
  wire [7:0] rx_byte = rx9 ? rx_sh_q[7:0] : rx_sh_q[8:1];
  wire rx_accept = rx_done && (!rx_full_q || rd_rx_data);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_buf_q <= 8'h00;
      rx_full_q <= 1'b0;
      framing_error_q <= 1'b0;
      overrun_error_q <= 1'b0;
      rx_ninth_data_q <= 1'b0;
    end else begin
      rx_full_q <= rx_accept || (rx_full_q && !rd_rx_data);
      if (rx_accept) begin
        rx_buf_q <= rx_byte;
        framing_error_q <= rx_framing_error_q;
        rx_ninth_data_q <= rx9 && rx_sh_q[8];
      end
      if (rx_done && !rx_accept) begin
        overrun_error_q <= 1'b1;
      end else if (!continuous_receive_enable) begin
        overrun_error_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b1;
      tx_clock_pin_drive <= 1'b1;
      tx_clock_pin_oe <= 1'b0;
      rx_data_pin_drive <= 1'b1;
      rx_data_pin_oe <= 1'b0;
    end else begin
      if (!master || (tx_empty && !rx_en_sync)) begin
        sclk_q <= 1'b1;
      end else if (bit_tick) begin
        sclk_q <= 1'b0;
      end else if (mid_tick) begin
        sclk_q <= 1'b1;
      end
      tx_clock_pin_drive <= sync_mode ? sclk_q : tx_line_q;
      tx_clock_pin_oe <= serial_port_enable && (sync_mode ? master : transmit_enable);
      rx_data_pin_drive <= tx_line_q;
      rx_data_pin_oe <= serial_port_enable && sync_mode && tx_run && !tx_empty;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_bit3_zero: assert property (wb_ack && !wb_we &&
    (idx_hit(idx, ucb_pkg::TX_CTRL_IDX) || idx_hit(idx, ucb_pkg::RCV_CTRL_IDX))
    |-> wb_dat_r[3] == 1'b0) else $error("unimplemented bit reads one");
  chk_empty_flag: assert property (req && !wb_we && idx_hit(idx, ucb_pkg::TX_CTRL_IDX)
    |=> wb_dat_r[ucb_pkg::SHIFT_EMPTY_BIT] == $past(tx_empty)) else $error("empty flag wrong");
  chk_overrun_hold: assert property (overrun_error_q && continuous_receive_enable |=> overrun_error_q)
    else $error("overrun cleared while continuous receive set");
  chk_overrun_clear: assert property (!continuous_receive_enable && !rx_done |=> !overrun_error_q)
    else $error("overrun not cleared");
  chk_single_clear: assert property (rx_done && master && !continuous_receive_enable && !wr_rcv_ctrl
    |=> !single_receive_enable) else $error("single receive not cleared");
  chk_rx_priority: assert property (rx_en_sync ##1 rx_en_sync |=> !rx_data_pin_oe)
    else $error("transmit drove data during sync receive");
  chk_port_off: assert property (!serial_port_enable |=> !tx_clock_pin_oe && !rx_data_pin_oe)
    else $error("pins driven while port disabled");
  chk_slave_clock: assert property (sync_mode && !master |=> !tx_clock_pin_oe)
    else $error("slave drives clock pin");
  chk_ro_bits: assert property (wr_rcv_ctrl && !rx_done && wb_dat_w[ucb_pkg::CONT_RX_BIT]
    |=> $stable(framing_error_q) && $stable(overrun_error_q)) else $error("status bits changed by write");
  chk_framing_error_update: assert property (rx_accept |=> framing_error_q == $past(rx_framing_error_q))
    else $error("framing flag not taken with byte");

  cov_async_byte: cover property (!sync_mode && rx_accept);
  cov_sync_master: cover property (master && rx_done);
  cov_overrun: cover property (rx_done && !rx_accept);
  cov_tx_frame: cover property (!tx_empty ##1 tx_empty);

endmodule : ucb_usart_ctrl

//--- design/ucb_pkg.sv
// Shared constants and types of the serial port control block
package ucb_pkg;

  // Register word indices; the byte address is four times the index
  localparam logic [9:0] RCV_CTRL_IDX = 10'h018;
  localparam logic [9:0] TX_DATA_IDX = 10'h019;
  localparam logic [9:0] RX_DATA_IDX = 10'h01A;
  localparam logic [9:0] TX_CTRL_IDX = 10'h098;
  localparam logic [9:0] BAUD_DIV_IDX = 10'h099;

  // Transmit status and control fields
  localparam int unsigned CLOCK_SOURCE_BIT = 7;
  localparam int unsigned TX_NINTH_SEL_BIT = 6;
  localparam int unsigned TRANSMIT_ENABLE_BIT = 5;
  localparam int unsigned SYNC_MODE_BIT = 4;
  localparam int unsigned HIGH_RATE_BIT = 2;
  localparam int unsigned SHIFT_EMPTY_BIT = 1;
  localparam int unsigned TX_NINTH_DATA_BIT = 0;

  // Receive status and control fields
  localparam int unsigned SERIAL_ENABLE_BIT = 7;
  localparam int unsigned RX_NINTH_SEL_BIT = 6;
  localparam int unsigned SINGLE_RX_BIT = 5;
  localparam int unsigned CONT_RX_BIT = 4;
  localparam int unsigned FRAMING_ERR_BIT = 2;
  localparam int unsigned OVERRUN_BIT = 1;
  localparam int unsigned RX_NINTH_DATA_BIT = 0;

  // Reset values and writable-bit masks
  localparam logic [7:0] TX_CTRL_RST = 8'h02;
  localparam logic [7:0] RCV_CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_DIV_RST = 8'h00;
  localparam logic [7:0] TX_CTRL_WMASK = 8'hF5;
  localparam logic [7:0] RCV_CTRL_WMASK = 8'hF0;

  // Oscillator divide ratios per bit, X+1 factored out
  localparam int unsigned PRESCALE = 4;
  localparam int unsigned ASYNC_LOW_DIV = 64;
  localparam int unsigned ASYNC_HIGH_DIV = 16;
  localparam int unsigned SYNC_DIV = 4;
  localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE - 1);
  localparam logic [1:0] PRESCALE_MID = 2'(PRESCALE / 4);
  localparam logic [3:0] POST_LOW_LAST = 4'(ASYNC_LOW_DIV / PRESCALE - 1);
  localparam logic [3:0] POST_HIGH_LAST = 4'(ASYNC_HIGH_DIV / PRESCALE - 1);
  localparam logic [3:0] POST_SYNC_LAST = 4'(SYNC_DIV / PRESCALE - 1);

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } ucb_rx_state_t;

endpackage : ucb_pkg

//--- design/ucb_sync2.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/100ps
module ucb_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_level,
  output logic [WIDTH-1:0] sync_level
);

  logic [WIDTH-1:0] meta_q;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_q[g] <= 1'b1;
          sync_level[g] <= 1'b1;
        end else begin
          meta_q[g] <= async_level[g];
          sync_level[g] <= meta_q[g];
        end
      end
    end
  endgenerate

endmodule : ucb_sync2

//--- design/ucb_baud_gen.sv
// Free-running 8-bit baud timer with prescaler and mode post-divider
`timescale 1ns/100ps
module ucb_baud_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] divisor,
  input wire logic restart,
  input wire logic sync_mode,
  input wire logic high_rate,
  output logic over_tick,
  output logic bit_tick,
  output logic mid_tick
);

  logic [1:0] presc_q;
  logic [7:0] timer_q;
  logic [3:0] post_q;

  wire step = presc_q == ucb_pkg::PRESCALE_LAST;
  wire [3:0] post_last = sync_mode ? ucb_pkg::POST_SYNC_LAST :
                         high_rate ? ucb_pkg::POST_HIGH_LAST : ucb_pkg::POST_LOW_LAST;
  assign over_tick = step && (timer_q == divisor);
  assign bit_tick = over_tick && (post_q == post_last);
  assign mid_tick = sync_mode && (presc_q == ucb_pkg::PRESCALE_MID) &&
                    (timer_q == {1'b0, divisor[7:1]});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_q <= 2'h0;
      timer_q <= 8'h00;
      post_q <= 4'h0;
    end else if (restart) begin
      presc_q <= 2'h0;
      timer_q <= 8'h00;
      post_q <= 4'h0;
    end else begin
      presc_q <= presc_q + 2'h1;
      if (step) begin
        timer_q <= over_tick ? 8'h00 : timer_q + 8'h01;
      end
      if (over_tick) begin
        // Mode change may leave post_q above the new last value
        post_q <= (post_q >= post_last) ? 4'h0 : post_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [14:0] gap_q;
  logic gap_ok_q;
  logic [3:0] last_q;
  logic [14:0] gap_want;
  always_comb begin
    gap_want = 15'({7'h00, divisor} + 15'h0001) * 15'({11'h000, post_last} + 15'h0001);
    gap_want = 15'(gap_want * 15'(ucb_pkg::PRESCALE));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_q <= 15'h0001;
      gap_ok_q <= 1'b0;
      last_q <= 4'h0;
    end else if (restart) begin
      gap_q <= 15'h0001;
      gap_ok_q <= 1'b0;
      last_q <= post_last;
    end else begin
      gap_q <= bit_tick ? 15'h0001 : gap_q + 15'h0001;
      // A mode change spoils the period in flight
      gap_ok_q <= (post_last != last_q) ? 1'b0 : (bit_tick ? 1'b1 : gap_ok_q);
      last_q <= post_last;
    end
  end

  chk_baud_period: assert property (@(posedge clk) disable iff (rst)
    bit_tick && gap_ok_q && $stable(divisor) && $stable(post_last) |-> gap_q == gap_want)
    else $error("baud tick period wrong");
  chk_timer_cleared: assert property (@(posedge clk) disable iff (rst)
    restart |=> timer_q == 8'h00 && presc_q == 2'h0)
    else $error("baud timer not cleared on divisor write");

endmodule : ucb_baud_gen

//--- test/ucb_peer.sv
// Serial peer model: async terminal and sync clock partner
`timescale 1ns/100ps
module ucb_peer (
  input wire logic clk,
  input wire logic tx_line,
  input wire logic data_line,
  output logic rx_line,
  output logic ck_line
);
  // Both lines idle at the mark level
  initial begin
    rx_line = 1'b1;
    ck_line = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Start, data LSB first, stop, then two idle bit times
  task automatic send_frame(input logic [8:0] d, input logic stop, input int nb, input int bc);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    f[nb+1] = stop;
    for (int i = 0; i < nb + 2; i++) begin
      rx_line <= f[i];
      repeat (bc) @(posedge clk);
    end
    rx_line <= 1'b1;
    repeat (2 * bc) @(posedge clk);
  endtask : send_frame

  // Samples each bit at its middle
  task automatic recv_frame(input int nb, input int bc, output logic [10:0] f);
    int w;
    f = '1;
    w = 0;
    while (tx_line !== 1'b0 && w < 20000) begin
      @(posedge clk);
      w++;
    end
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i < nb + 2; i++) begin
      f[i] = tx_line;
      repeat (bc) @(posedge clk);
    end
  endtask : recv_frame

  // Takes data on rising clock edges, measures the clock period
  task automatic master_recv(output logic [7:0] d, output int per);
    int w;
    int t0;
    logic prev;
    w = 0;
    t0 = 0;
    per = 0;
    for (int i = 0; i < 8; i++) begin
      do begin
        prev = tx_line;
        @(posedge clk);
        w++;
      end while (!(prev === 1'b0 && tx_line === 1'b1) && w < 20000);
      d[i] = data_line;
      if (i == 1) per = w - t0;
      t0 = w;
    end
  endtask : master_recv

  // Link clock of 160 ns, standing at 1 between frames
  task automatic slave_recv(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      ck_line <= 1'b0;
      repeat (8) @(posedge clk);
      d[i] = data_line;
      ck_line <= 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask : slave_recv
endmodule : ucb_peer

//--- test/ucb_usart_ctrl_test.sv
// Self-checking bench of the serial port control block
`timescale 1ns/100ps
module ucb_usart_ctrl_test;
  localparam logic [11:0] A_RC = {ucb_pkg::RCV_CTRL_IDX, 2'b00};
  localparam logic [11:0] A_TD = {ucb_pkg::TX_DATA_IDX, 2'b00};
  localparam logic [11:0] A_RD = {ucb_pkg::RX_DATA_IDX, 2'b00};
  localparam logic [11:0] A_TC = {ucb_pkg::TX_CTRL_IDX, 2'b00};
  localparam logic [11:0] A_BD = {ucb_pkg::BAUD_DIV_IDX, 2'b00};
  logic clk;
  logic rst;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [11:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic tx_drive;
  logic tx_oe;
  logic rx_drive;
  logic rx_oe;
  logic rx_line;
  logic ck_line;
  wire tx_pin;
  wire rx_pin;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [10:0] f;
  logic [7:0] d;
  int per;

  // Pin levels from the DUT's enables, else the peer's lines
  assign tx_pin = tx_oe ? tx_drive : ck_line;
  assign rx_pin = rx_oe ? rx_drive : rx_line;

  ucb_usart_ctrl dut (.clk(clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .tx_clock_pin_level(tx_pin), .tx_clock_pin_drive(tx_drive),
    .tx_clock_pin_oe(tx_oe), .rx_data_pin_level(rx_pin), .rx_data_pin_drive(rx_drive),
    .rx_data_pin_oe(rx_oe));

  ucb_peer peer (.clk(clk), .tx_line(tx_pin), .data_line(rx_pin), .rx_line(rx_line),
    .ck_line(ck_line));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (mismatches == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [11:0] a, input logic [7:0] v,
                         output logic [31:0] r);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= {24'h00_0000, v};
    do begin
      @(posedge clk);
    end while (wb_ack !== 1'b1);
    r = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb_xfer

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] r;
    wb_xfer(1'b0, a, 8'h00, r);
    chk(r, {24'h00_0000, exp});
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] r;
    wb_xfer(1'b1, a, v, r);
  endtask : wr

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 12'h000;
    wb_sel = 4'h1;
    wb_dat_w = 32'h0000_0000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(A_TC, 8'h02);
    rd(A_RC, 8'h00);
    rd(A_BD, 8'h00);
    rd(12'h3F0, 8'h00);
    wr(A_TC, 8'hFF);
    rd(A_TC, 8'hF7);
    wr(A_TC, 8'h00);
    wr(A_RC, 8'h4F);
    rd(A_RC, 8'h40);
    wr(A_BD, 8'h01);
    rd(A_BD, 8'h01);
    // Async transmit, low rate, X=1
    wr(A_TC, 8'h20);
    wr(A_RC, 8'h80);
    wr(A_TD, 8'hA5);
    fork
      peer.recv_frame(8, 128, f);
      rd(A_TC, 8'h20);
    join
    chk({21'h00_0000, f}, {21'h00_0000, 2'b11, 8'hA5, 1'b0});
    rd(A_TC, 8'h22);
    // Nine-bit, high rate
    wr(A_TC, 8'h64);
    wr(A_TD, 8'h3C);
    peer.recv_frame(9, 32, f);
    chk({21'h00_0000, f}, {21'h00_0000, 2'b10, 8'h3C, 1'b0});
    // Async receive, X=0
    wr(A_TC, 8'h00);
    wr(A_BD, 8'h00);
    wr(A_RC, 8'h90);
    peer.send_frame(9'h05A, 1'b1, 8, 64);
    rd(A_RC, 8'h90);
    rd(A_RD, 8'h5A);
    peer.send_frame(9'h033, 1'b0, 8, 64);
    rd(A_RC, 8'h94);
    rd(A_RD, 8'h33);
    peer.send_frame(9'h011, 1'b1, 8, 64);
    peer.send_frame(9'h022, 1'b1, 8, 64);
    rd(A_RC, 8'h92);
    wr(A_RC, 8'h97);
    rd(A_RC, 8'h92);
    wr(A_RC, 8'h80);
    rd(A_RC, 8'h80);
    rd(A_RD, 8'h11);
    wr(A_RC, 8'hD0);
    peer.send_frame(9'h1A5, 1'b1, 9, 64);
    rd(A_RC, 8'hD1);
    rd(A_RD, 8'hA5);
    // Sync master transmit, X=1
    wr(A_RC, 8'h80);
    wr(A_BD, 8'h01);
    wr(A_TC, 8'hB0);
    fork
      peer.master_recv(d, per);
      wr(A_TD, 8'hC3);
    join
    chk({24'h00_0000, d}, 32'h0000_00C3);
    chk(32'(per), 32'h0000_0008);
    // Single receive in sync master
    wr(A_TC, 8'h90);
    wr(A_RC, 8'hA0);
    repeat (96) @(posedge clk);
    rd(A_RC, 8'h80);
    rd(A_RD, 8'hFF);
    // Sync slave transmit on the link clock
    wr(A_RC, 8'h80);
    wr(A_TC, 8'h30);
    wr(A_TD, 8'h96);
    peer.slave_recv(d);
    chk({24'h00_0000, d}, 32'h0000_0096);
    end_of_test();
  end
endmodule : ucb_usart_ctrl_test
